// ==== design/timer3_reload_split_capture.sv ====
`timescale 1ns/1ps
`default_nettype none
module timer3_reload_split_capture
  import timer3_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire timer_cfg_t cfg,
  input wire logic suspend,
  input wire logic wake_other,
  input wire logic ext_osc_clk,
  input wire logic comparator_out,
  input wire logic count_wr,
  input wire count_word_t count_wdata,
  input wire logic reload_wr,
  input wire count_word_t reload_wdata,
  input wire logic clr_high_flag,
  input wire logic clr_low_flag,
  output count_word_t count_value,
  output count_word_t reload_value,
  output logic high_overflow_flag,
  output logic low_overflow_flag,
  output logic irq,
  output logic wake,
  output logic sync_status_bit
);

  ////////////////////////////////////////////////////////////////////////////
  // clock sources
  logic [3:0] presc_reg, presc_next;
  logic [2:0] ext_div_reg, ext_div_next;
  logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
  logic ext_tick, div12_tick;
  logic [1:0] sync_cnt_reg, sync_cnt_next;
  logic cmp_reg;

  always_comb
  begin
    presc_next = (presc_reg == presc_last) ? 4'h0 : presc_reg + 4'h1;
    div12_tick = (presc_reg == presc_last);
    ext_tick = ext_s2_reg & ~ext_s3_reg;
    // ext/8: counts synchronised rising edges
    ext_div_next = ext_tick ? ext_div_reg + 3'h1 : ext_div_reg;
  end

  logic ext_fire;
  assign ext_fire = ext_tick && ext_div_reg == ext_last;

  ////////////////////////////////////////////////////////////////////////////
  // counter state
  count_word_t cnt_reg, cnt_next, rl_reg, rl_next;
  logic hf_reg, hf_next, lf_reg, lf_next, irq_reg, irq_next;
  logic capture, cap_edge, tick_l, tick_h, run_h;
  logic ovf_l, ovf_h, ovf16;

  function automatic logic pick_tick(input logic sel, input logic xsel,
                                     input logic cap);
    if (sel)
      pick_tick = 1'b1;
    else if (xsel && !cap)
      pick_tick = ext_fire;
    else
      pick_tick = div12_tick;
  endfunction : pick_tick

  always_comb
  begin
    capture = cfg.capture_enable_bit & ~cfg.split_mode_bit;
    cap_edge = capture & comparator_out & ~cmp_reg;
    // capture: ext clock not offered, falls back to /12
    tick_l = pick_tick(cfg.low_byte_clock_select,
                       cfg.external_clock_select, capture);
    tick_h = pick_tick(cfg.high_byte_clock_select,
                       cfg.external_clock_select, capture);
    run_h = cfg.run_control_bit;
    cnt_next = cnt_reg;
    rl_next = rl_reg;
    ovf_l = 1'b0;
    ovf_h = 1'b0;
    ovf16 = 1'b0;
    if (cfg.split_mode_bit)
    begin
      // low byte always runs; high byte gated
      if (tick_l)
      begin
        ovf_l = cnt_reg.count_low_byte == 8'hff;
        cnt_next.count_low_byte = ovf_l ? rl_reg.count_low_byte
                                  : cnt_reg.count_low_byte + 8'h01;
      end
      if (run_h && tick_h)
      begin
        ovf_h = cnt_reg.count_high_byte == 8'hff;
        cnt_next.count_high_byte = ovf_h ? rl_reg.count_high_byte
                                   : cnt_reg.count_high_byte + 8'h01;
      end
    end
    else if (run_h && tick_l)
    begin
      ovf_l = cnt_reg.count_low_byte == 8'hff;
      ovf16 = cnt_reg == 16'hffff;
      if (ovf16 && !capture)
        cnt_next = rl_reg;
      else
        cnt_next = cnt_reg + 16'h0001;
    end
    if (cap_edge)
      rl_next = cnt_reg;
    if (reload_wr)
      rl_next = reload_wdata;
    if (count_wr)
      cnt_next = count_wdata;
    // set beats clear; no hardware clear
    hf_next = (hf_reg & ~clr_high_flag) | ovf_h | ovf16
              | cap_edge;
    lf_next = (lf_reg & ~clr_low_flag) | ovf_l;
    irq_next = cfg.timer_interrupt_enable & (hf_next
               | (cfg.low_byte_interrupt_enable & lf_next));
  end

  ////////////////////////////////////////////////////////////////////////////
  // suspend sync status
  always_comb
  begin
    sync_cnt_next = sync_cnt_reg;
    if (suspend && wake_other)
      sync_cnt_next = sync_clocks;
    else if (sync_cnt_reg != 2'h0 && ext_fire)
      sync_cnt_next = sync_cnt_reg - 2'h1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      presc_reg <= 4'h0;
      ext_div_reg <= 3'h0;
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
      cmp_reg <= 1'b0;
      cnt_reg <= count_reset;
      rl_reg <= reload_reset;
      hf_reg <= 1'b0;
      lf_reg <= 1'b0;
      irq_reg <= 1'b0;
      sync_cnt_reg <= 2'h0;
    end
    else
    begin
      presc_reg <= presc_next;
      ext_div_reg <= ext_div_next;
      ext_s1_reg <= ext_osc_clk;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      cmp_reg <= comparator_out;
      cnt_reg <= cnt_next;
      rl_reg <= rl_next;
      hf_reg <= hf_next;
      lf_reg <= lf_next;
      irq_reg <= irq_next;
      sync_cnt_reg <= sync_cnt_next;
    end
  end

  assign count_value = cnt_reg;
  assign reload_value = rl_reg;
  assign high_overflow_flag = hf_reg;
  assign low_overflow_flag = lf_reg;
  assign irq = irq_reg;
  assign wake = suspend & hf_reg;
  assign sync_status_bit = sync_cnt_reg != 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_wrap16;
    !cfg.split_mode_bit && !capture && run_h && tick_l && cnt_reg == 16'hffff
      && !count_wr;
  endsequence

  property p_reload16;
    @(posedge ref_clk) disable iff (!rst_n)
      s_wrap16 |=> cnt_reg == $past(rl_reg) && hf_reg;
  endproperty
  a_reload16: assert property (p_reload16) else $error("no reload");

  property p_irq16;
    @(posedge ref_clk) disable iff (!rst_n)
      (s_wrap16 and cfg.timer_interrupt_enable) ##1
      cfg.timer_interrupt_enable |-> irq;
  endproperty
  a_irq16: assert property (p_irq16) else $error("no irq");

  property p_low_irq;
    @(posedge ref_clk) disable iff (!rst_n)
      (lf_reg && cfg.timer_interrupt_enable && cfg.low_byte_interrupt_enable
       && !clr_low_flag) |=> irq;
  endproperty
  a_low_irq: assert property (p_low_irq) else $error("no low irq");

  property p_split_low;
    @(posedge ref_clk) disable iff (!rst_n)
      (cfg.split_mode_bit && tick_l && cnt_reg.count_low_byte == 8'hff
       && !count_wr) |=> lf_reg
      && cnt_reg.count_low_byte == $past(rl_reg.count_low_byte);
  endproperty
  a_split_low: assert property (p_split_low)
    else $error("split low");

  property p_high_gate;
    @(posedge ref_clk) disable iff (!rst_n)
      (cfg.split_mode_bit && !run_h && !count_wr) |=>
      cnt_reg.count_high_byte == $past(cnt_reg.count_high_byte);
  endproperty
  a_high_gate: assert property (p_high_gate) else $error("high ran");

  property p_flag_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (hf_reg && !clr_high_flag) |=> hf_reg;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");

  property p_capture;
    @(posedge ref_clk) disable iff (!rst_n)
      (cap_edge && !reload_wr) |=> rl_reg == $past(cnt_reg) && hf_reg;
  endproperty
  a_capture: assert property (p_capture) else $error("no capture");

  property p_no_cap_split;
    @(posedge ref_clk) disable iff (!rst_n)
      (cfg.split_mode_bit && comparator_out && !cmp_reg && !reload_wr) |=>
      rl_reg == $past(rl_reg);
  endproperty
  a_no_cap_split: assert property (p_no_cap_split) else $error("cap");

  property p_sync;
    @(posedge ref_clk) disable iff (!rst_n)
      (suspend && wake_other) |=> sync_status_bit;
  endproperty
  a_sync: assert property (p_sync) else $error("no sync");

  sequence s_high_wrap;
    cfg.split_mode_bit && run_h && tick_h && cnt_reg.count_high_byte == 8'hff
      && !count_wr;
  endsequence

  property p_split_high;
    @(posedge ref_clk) disable iff (!rst_n)
      s_high_wrap |=> hf_reg
      && cnt_reg.count_high_byte == $past(rl_reg.count_high_byte);
  endproperty
  a_split_high: assert property (p_split_high)
    else $error("high wrap");

  property p_low_free;
    @(posedge ref_clk) disable iff (!rst_n)
      (cfg.split_mode_bit && tick_l && cnt_reg.count_low_byte != 8'hff
       && !count_wr) |=>
      cnt_reg.count_low_byte == $past(cnt_reg.count_low_byte) + 8'h01;
  endproperty
  a_low_free: assert property (p_low_free) else $error("low held");

  property p_cap_run;
    @(posedge ref_clk) disable iff (!rst_n)
      (capture && run_h && tick_l && !count_wr) |=>
      cnt_reg == $past(cnt_reg) + 16'h0001;
  endproperty
  a_cap_run: assert property (p_cap_run) else $error("cap reload");

  property p_wake;
    @(posedge ref_clk) disable iff (!rst_n)
      (s_wrap16 and suspend) ##1 suspend |-> wake;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");

  property p_div12;
    @(posedge ref_clk) disable iff (!rst_n)
      div12_tick |-> ##12 div12_tick;
  endproperty
  a_div12: assert property (p_div12) else $error("div12");

  property p_ext_fire;
    @(posedge ref_clk) disable iff (!rst_n)
      ext_fire |=> ext_div_reg == 3'h0;
  endproperty
  a_ext_fire: assert property (p_ext_fire) else $error("ext div");

  sequence s_sync_last;
    sync_cnt_reg == 2'h1 && ext_fire && !(suspend && wake_other);
  endsequence

  property p_sync_drop;
    @(posedge ref_clk) disable iff (!rst_n)
      s_sync_last |=> !sync_status_bit;
  endproperty
  a_sync_drop: assert property (p_sync_drop) else $error("sync");

  property p_sync_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      (sync_status_bit && !ext_fire) |=> sync_status_bit;
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("sync lost");

  property p_irq_off;
    @(posedge ref_clk) disable iff (!rst_n)
      !cfg.timer_interrupt_enable |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("stray irq");

  property p_hf_cause;
    @(posedge ref_clk) disable iff (!rst_n)
      (!hf_reg && !ovf_h && !ovf16 && !cap_edge) |=> !hf_reg;
  endproperty
  a_hf_cause: assert property (p_hf_cause) else $error("high set");

  property p_lf_cause;
    @(posedge ref_clk) disable iff (!rst_n)
      (!lf_reg && !ovf_l) |=> !lf_reg;
  endproperty
  a_lf_cause: assert property (p_lf_cause) else $error("low set");

endmodule : timer3_reload_split_capture
`default_nettype wire

// ==== design/timer3_pkg.sv ====
// Summary of operation
// - count is low byte plus high byte
// - split bit picks 16-bit or two 8-bit
// - clocks: system, system/12, external/8
// - external/8 always synchronised, in suspend too
// - counts in suspend, 16-bit or high-byte overflow wakes device (split low-byte overflow does not)
// - sync status high up to three clocks
// - 16-bit rollover reloads (wraps to 0 in capture), sets high flag
// - 16-bit overflow interrupts when enabled
// - low-byte rollover interrupts with low enable
// - split halves reload from own reload bytes
// - split: run bit gates high byte only
// - per-byte select: system, /12 or ext/8
// - split: each byte sets own flag
// - split interrupts: high byte, or low byte with low enable
// - flags cleared only by software
// - capture needs capture bit and not split
// - comparator rise copies count, sets flag
// - capture counts from system or system/12
package timer3_pkg;

  localparam logic [15:0] count_reset = 16'h0000;
  localparam logic [15:0] reload_reset = 16'h0000;
  localparam int system_clock_div = 12;
  localparam int ext_div = 8;
  localparam logic [3:0] presc_last = 4'hb;
  localparam logic [2:0] ext_last = 3'h7;
  localparam logic [1:0] sync_clocks = 2'h3;

  typedef struct packed {
    logic split_mode_bit;
    logic run_control_bit;
    logic external_clock_select;
    logic high_byte_clock_select;
    logic low_byte_clock_select;
    logic low_byte_interrupt_enable;
    logic capture_enable_bit;
    logic timer_interrupt_enable;
  } timer_cfg_t;

  typedef struct packed {
    logic [7:0] count_high_byte;
    logic [7:0] count_low_byte;
  } count_word_t;

endpackage : timer3_pkg

// ==== verification/timer3_far_side.sv ====
`timescale 1ns/1ps
`default_nettype none
module timer3_far_side (
  input wire logic ref_clk,
  input wire logic ext_run,
  input wire logic cmp_fire,
  output logic ext_osc_clk,
  output logic comparator_out
);
  logic [1:0] ph_reg = 2'h0;
  ////////////////////////////////////////////////////////////////////////
  // external oscillator, still unless asked; toggles every third clock
  initial
  begin
    ext_osc_clk = 1'b0;
    comparator_out = 1'b0;
  end
  always @(posedge ref_clk)
  begin
    ph_reg <= (!ext_run || ph_reg == 2'h2) ? 2'h0 : ph_reg + 2'h1;
    if (ext_run && ph_reg == 2'h2)
      ext_osc_clk <= ~ext_osc_clk;
  end
  // comparator edge on request
  always @(posedge ref_clk)
    comparator_out <= cmp_fire;
endmodule : timer3_far_side
`default_nettype wire

// ==== verification/timer3_reload_split_capture_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module timer3_reload_split_capture_test
  import timer3_pkg::*;
;
  logic ref_clk, rst_n, suspend, wake_other, ext_osc_clk, comparator_out;
  logic count_wr, reload_wr, clr_high_flag, clr_low_flag, ext_run, cmp_fire;
  logic hf, lf, irq, wake, sync_status_bit;
  timer_cfg_t cfg;
  count_word_t count_wdata, reload_wdata, count_value, reload_value;
  int n_errors = 0;
  int n_checks = 0;
  timer3_reload_split_capture u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .cfg(cfg), .suspend(suspend), .wake_other(wake_other),
    .ext_osc_clk(ext_osc_clk), .comparator_out(comparator_out),
    .count_wr(count_wr), .count_wdata(count_wdata), .reload_wr(reload_wr),
    .reload_wdata(reload_wdata), .clr_high_flag(clr_high_flag),
    .clr_low_flag(clr_low_flag), .count_value(count_value),
    .reload_value(reload_value), .high_overflow_flag(hf),
    .low_overflow_flag(lf), .irq(irq), .wake(wake),
    .sync_status_bit(sync_status_bit));
  timer3_far_side u_far (.ref_clk(ref_clk), .ext_run(ext_run),
    .cmp_fire(cmp_fire), .ext_osc_clk(ext_osc_clk),
    .comparator_out(comparator_out));
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task print_verdict;
    if (n_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // bounded wait on a flag, one cycle at a time
  task wait_for(input bit lo, input int lim);
    int i;
    for (i = 0; i < lim && (lo ? lf : (hf | wake)) !== 1'b1; i++)
      @(negedge ref_clk);
    if (i == lim)
    begin
      n_errors++;
      print_verdict;
    end
  endtask : wait_for
  task load(input logic [15:0] cnt, input logic [15:0] rld);
    count_wr = 1'b1;
    reload_wr = 1'b1;
    count_wdata = cnt;
    reload_wdata = rld;
    @(negedge ref_clk);
    count_wr = 1'b0;
    reload_wr = 1'b0;
  endtask : load
  task clear_flags;
    clr_high_flag = 1'b1;
    clr_low_flag = 1'b1;
    @(negedge ref_clk);
    clr_high_flag = 1'b0;
    clr_low_flag = 1'b0;
  endtask : clear_flags
  // two comparator rises gap cycles apart, compare captured difference
  task cap_gap(input int gap, input logic [15:0] exp);
    logic [15:0] first;
    cmp_fire = 1'b1;
    repeat (3) @(negedge ref_clk);
    first = reload_value;
    cmp_fire = 1'b0;
    repeat (gap - 3) @(negedge ref_clk);
    cmp_fire = 1'b1;
    repeat (3) @(negedge ref_clk);
    cmp_fire = 1'b0;
    chk("period", reload_value - first, exp);
  endtask : cap_gap
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    {suspend, wake_other, count_wr, reload_wr} = 4'h0;
    {clr_high_flag, clr_low_flag, ext_run, cmp_fire} = 4'h0;
    cfg = '0;
    count_wdata = '0;
    reload_wdata = '0;
    repeat (4) @(negedge ref_clk);
    rst_n = 1'b1;
    chk("count", count_value, 16'h0000);
    chk("flags", {hf, lf, irq}, 16'h0000);
    // 16-bit rollover reloads and interrupts
    load(16'hfffd, 16'h1234);
    cfg.run_control_bit = 1'b1;
    cfg.low_byte_clock_select = 1'b1;
    cfg.timer_interrupt_enable = 1'b1;
    wait_for(1'b0, 20);
    chk("count", count_value, 16'h1234);
    @(negedge ref_clk);
    chk("irq", irq, 16'h0001);
    repeat (5) @(negedge ref_clk);
    chk("hflag", hf, 16'h0001);
    cfg.run_control_bit = 1'b0;
    clear_flags;
    // split: low runs, high gated off
    cfg.split_mode_bit = 1'b1;
    cfg.high_byte_clock_select = 1'b1;
    cfg.low_byte_interrupt_enable = 1'b1;
    load(16'h40ff, 16'h7788);
    wait_for(1'b1, 20);
    chk("count", count_value, 16'h4088);
    chk("hflag", hf, 16'h0000);
    @(negedge ref_clk);
    chk("irq", irq, 16'h0001);
    chk("lflag", lf, 16'h0001);
    clear_flags;
    chk("flags", {hf, lf}, 16'h0000);
    // capture with stopped counter
    cfg = '0;
    cfg.capture_enable_bit = 1'b1;
    cfg.low_byte_clock_select = 1'b1;
    cfg.timer_interrupt_enable = 1'b1;
    load(16'h5a5a, 16'h0000);
    cmp_fire = 1'b1;
    wait_for(1'b0, 20);
    chk("reload", reload_value, 16'h5a5a);
    chk("count", count_value, 16'h5a5a);
    @(negedge ref_clk);
    chk("irq", irq, 16'h0001);
    cmp_fire = 1'b0;
    clear_flags;
    // running capture: differences of captures give the period
    cfg.run_control_bit = 1'b1;
    cap_gap(10, 16'h000a);
    chk("count", count_value - reload_value, 16'h0002);
    cfg.low_byte_clock_select = 1'b0;
    @(negedge ref_clk);
    cap_gap(24, 16'h0002);
    clear_flags;
    // external clock/8 wakes from suspend
    cfg = '0;
    cfg.run_control_bit = 1'b1;
    cfg.external_clock_select = 1'b1;
    load(16'hfffe, 16'h0000);
    suspend = 1'b1;
    ext_run = 1'b1;
    wait_for(1'b0, 400);
    chk("wake", wake, 16'h0001);
    chk("count", count_value, 16'h0000);
    wake_other = 1'b1;
    @(negedge ref_clk);
    wake_other = 1'b0;
    chk("sync", sync_status_bit, 16'h0001);
    repeat (200) @(negedge ref_clk);
    chk("sync", sync_status_bit, 16'h0000);
    print_verdict;
  end
endmodule : timer3_reload_split_capture_test
`default_nettype wire
